// ### rtl/flash_seq.v
// serial flash cache, streaming fetch and register-driven command engine
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.vh"

// small synchronous fifo with valid/ready on both sides
module flash_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  localparam [AW:0] FULL_CNT = DEPTH;

  // honest full and empty from the occupancy count
  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers and count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // flash_byte_fifo

module flash_seq (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire FETCH_REQ,
  input wire [23:0] FETCH_ADDR,
  output reg FETCH_READY,
  output reg [7:0] FETCH_DATA,
  input wire LINK_CLK,
  input wire SERIAL_DATA_IN,
  output reg SPI_CS_N,
  output reg SPI_CLK,
  output reg SPI_DO
);
  // byte of the command buffer, don't care past its end
  function [7:0] cmd_byte;
    input [63:0] buf_v;
    input [7:0] idx;
    begin
      if (idx < `BUF_BYTES) begin
        cmd_byte = buf_v[idx[2:0]*8 +: 8];
      end else begin
        cmd_byte = `DONT_CARE_BYTE;
      end
    end
  endfunction

  // byte of the fast read header: opcode, address msb first, dummy
  function [7:0] fr_byte;
    input [23:0] addr;
    input [7:0] idx;
    begin
      case (idx)
        8'h00: fr_byte = `OP_FAST_READ;
        8'h01: fr_byte = addr[23:16];
        8'h02: fr_byte = addr[15:8];
        8'h03: fr_byte = addr[7:0];
        default: fr_byte = `DONT_CARE_BYTE;
      endcase
    end
  endfunction

  reg lk_s1_r, lk_s2_r, lk_s3_r;
  reg di_s1_r, di_s2_r;
  reg [1:0] st_r;
  reg fast_r;
  reg go_r;
  reg [7:0] len_r;
  reg [63:0] cmd_r;
  reg [63:0] rsp_r;
  reg [7:0] byte_idx_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] sh_out_r;
  reg [7:0] sh_in_r;
  reg pend_r;
  reg [23:0] faddr_r;
  reg [23:0] nxt_r;
  reg [23:0] base_r;
  reg [5:0] clen_r;
  reg [7:0] cache_mem [0:31];
  reg push_r;
  reg [7:0] push_data_r;
  wire lk_rise, lk_fall;
  wire fifo_in_ready, fifo_out_valid, fifo_pop;
  wire [7:0] fifo_out_data;
  wire [23:0] hit_off;
  wire hit;
  wire bus_acc, bus_wr, mapped;
  wire [7:0] next_byte;
  wire [2:0] rsp_slot;
  wire [7:0] fr_op;

  // link clock and data input pass two flops first
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      lk_s3_r <= 1'b0;
      di_s1_r <= 1'b0;
      di_s2_r <= 1'b0;
    end else begin
      lk_s1_r <= LINK_CLK;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
      di_s1_r <= SERIAL_DATA_IN;
      di_s2_r <= di_s1_r;
    end
  end

  assign lk_rise = lk_s2_r & ~lk_s3_r;
  assign lk_fall = ~lk_s2_r & lk_s3_r;

  // cache range check against base and length
  assign hit_off = FETCH_ADDR - base_r;
  assign hit = (hit_off < {18'h0, clen_r});

  // apb decode, one wait state
  assign bus_acc = PSEL & PENABLE & PREADY;
  assign bus_wr = bus_acc & PWRITE;
  assign mapped = (PADDR == `OFS_CTRL) | (PADDR == `OFS_LEN) |
                  (PADDR == `OFS_CMD_LO) | (PADDR == `OFS_CMD_HI) |
                  (PADDR == `OFS_RSP_LO) | (PADDR == `OFS_RSP_HI);

  // following byte to shift out in the current transfer
  assign next_byte = fast_r ? fr_byte(faddr_r, byte_idx_r + 8'h01)
                            : cmd_byte(cmd_r, byte_idx_r + 8'h01);

  // response slot of the byte just received, kept to three bits
  assign rsp_slot = byte_idx_r[2:0] - 3'd1;
  assign fr_op = `OP_FAST_READ;

  // drain side stalls while an answer is being presented
  assign fifo_pop = fifo_out_valid & ~FETCH_READY;

  flash_byte_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(push_data_r),
    .out_valid(fifo_out_valid),
    .out_ready(~FETCH_READY),
    .out_data(fifo_out_data)
  );

  // cache storage, indexed by low address bits as a ring
  always @(posedge CLK) begin
    if (fifo_pop) begin
      cache_mem[faddr_r[4:0]] <= fifo_out_data;
    end
  end

  // apb answer and register reads
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        case (PADDR)
          `OFS_CTRL: PRDATA <= {30'h0, (fast_r & ~SPI_CS_N), go_r};
          `OFS_LEN: PRDATA <= {24'h000000, len_r};
          `OFS_CMD_LO: PRDATA <= cmd_r[31:0];
          `OFS_CMD_HI: PRDATA <= cmd_r[63:32];
          `OFS_RSP_LO: PRDATA <= rsp_r[31:0];
          `OFS_RSP_HI: PRDATA <= rsp_r[63:32];
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // engine: fetch handling, cache pointers, serial shifting
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= `ST_IDLE;
      fast_r <= 1'b0;
      go_r <= 1'b0;
      len_r <= `LEN_RESET;
      cmd_r <= `CMD_RESET;
      rsp_r <= `RSP_RESET;
      byte_idx_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      sh_out_r <= 8'h00;
      sh_in_r <= 8'h00;
      pend_r <= 1'b0;
      faddr_r <= 24'h000000;
      nxt_r <= 24'h000000;
      base_r <= 24'h000000;
      clen_r <= 6'h00;
      push_r <= 1'b0;
      push_data_r <= 8'h00;
      SPI_CS_N <= 1'b1;
      SPI_CLK <= 1'b0;
      SPI_DO <= 1'b0;
      FETCH_READY <= 1'b0;
      FETCH_DATA <= 8'h00;
    end else begin
      push_r <= 1'b0;
      FETCH_READY <= 1'b0;
      // software writes; command registers are free whenever the engine is not shifting
      if (bus_wr && st_r != `ST_SHIFT) begin
        case (PADDR)
          `OFS_LEN: len_r <= PWDATA[7:0];
          `OFS_CMD_LO: cmd_r[31:0] <= PWDATA;
          `OFS_CMD_HI: cmd_r[63:32] <= PWDATA;
          default: ;
        endcase
      end
      // fifo drained: answer the fetch and fill the cache
      if (fifo_pop) begin
        FETCH_READY <= 1'b1;
        FETCH_DATA <= fifo_out_data;
        pend_r <= 1'b0;
        if (clen_r == `CACHE_BYTES) begin
          base_r <= base_r + 24'h000001;
        end else begin
          clen_r <= clen_r + 6'h01;
        end
      end
      // new fetch request
      if (FETCH_REQ && !pend_r && !FETCH_READY) begin
        if (st_r == `ST_WAIT && FETCH_ADDR != nxt_r) begin
          st_r <= `ST_IDLE;
          SPI_CS_N <= 1'b1;
        end
        if (hit) begin
          FETCH_READY <= 1'b1;
          FETCH_DATA <= cache_mem[FETCH_ADDR[4:0]];
        end else begin
          pend_r <= 1'b1;
          faddr_r <= FETCH_ADDR;
        end
      end
      case (st_r)
        `ST_IDLE: begin
          SPI_CLK <= 1'b0;
          if (lk_fall && pend_r && !fifo_pop && fifo_in_ready) begin
            // jump: open a fast read at the new address
            st_r <= `ST_SHIFT;
            fast_r <= 1'b1;
            base_r <= faddr_r;
            clen_r <= 6'h00;
            byte_idx_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            sh_out_r <= {fr_op[6:0], 1'b0};
            SPI_DO <= fr_op[7];
            SPI_CS_N <= 1'b0;
          end else if (lk_fall && go_r && !pend_r) begin
            if (len_r == 8'h00) begin
              go_r <= 1'b0;
            end else begin
              st_r <= `ST_SHIFT;
              fast_r <= 1'b0;
              clen_r <= 6'h00;
              byte_idx_r <= 8'h00;
              bit_cnt_r <= 4'h0;
              sh_out_r <= {cmd_r[6:0], 1'b0};
              SPI_DO <= cmd_r[7];
              SPI_CS_N <= 1'b0;
            end
          end
        end
        `ST_WAIT: begin
          SPI_CLK <= 1'b0;
          if (lk_fall && pend_r && faddr_r == nxt_r && !fifo_pop && fifo_in_ready) begin
            // sequential: clock one more byte in
            st_r <= `ST_SHIFT;
            byte_idx_r <= `FR_DATA_IDX;
            bit_cnt_r <= 4'h0;
            sh_out_r <= `DONT_CARE_BYTE;
            SPI_DO <= 1'b0;
          end
        end
        `ST_SHIFT: begin
          SPI_CLK <= lk_s2_r;
          if (lk_rise) begin
            sh_in_r <= {sh_in_r[6:0], di_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (lk_fall && bit_cnt_r == `BITS_PER_BYTE) begin
            // byte complete
            bit_cnt_r <= 4'h0;
            byte_idx_r <= byte_idx_r + 8'h01;
            sh_out_r <= {next_byte[6:0], 1'b0};
            SPI_DO <= next_byte[7];
            if (fast_r) begin
              if (byte_idx_r >= `FR_DATA_IDX) begin
                push_r <= 1'b1;
                push_data_r <= sh_in_r;
                nxt_r <= faddr_r + 24'h000001;
                st_r <= `ST_WAIT;
              end
            end else begin
              if (byte_idx_r != 8'h00 && byte_idx_r <= `BUF_BYTES) begin
                rsp_r[rsp_slot*8 +: 8] <= sh_in_r;
              end
              if (byte_idx_r + 8'h01 == len_r) begin
                st_r <= `ST_IDLE;
                SPI_CS_N <= 1'b1;
                go_r <= 1'b0;
              end
            end
          end else if (lk_fall) begin
            SPI_DO <= sh_out_r[7];
            sh_out_r <= {sh_out_r[6:0], 1'b0};
          end
        end
        default: st_r <= `ST_IDLE;
      endcase
      // start bit: a set wins over a same-cycle clear in idle, and is ignored while shifting
      if (bus_wr && PADDR == `OFS_CTRL && PWDATA[`CTRL_GO_BIT] && st_r != `ST_SHIFT) begin
        go_r <= 1'b1;
      end
    end
  end
endmodule // flash_seq
`default_nettype wire

// ### pkg/flash_seq_defines.vh
// constants for the serial flash cache and command engine
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LEN 8'h04
`define OFS_CMD_LO 8'h08
`define OFS_CMD_HI 8'h0c
`define OFS_RSP_LO 8'h10
`define OFS_RSP_HI 8'h14
// control register fields
`define CTRL_GO_BIT 0
`define CTRL_STREAM_BIT 1
// reset values
`define LEN_RESET 8'h00
`define CMD_RESET 64'h0000000000000000
`define RSP_RESET 64'h0000000000000000
// buffer and cache geometry
`define BUF_BYTES 8'h08
`define CACHE_BYTES 6'h20
// fast read sequence
`define OP_FAST_READ 8'h0b
`define DONT_CARE_BYTE 8'h00
`define FR_DATA_IDX 8'h05
// opcodes software places in the command buffer
`define OP_SECTOR_WIPE 8'h20
`define OP_SMALL_BLOCK_WIPE 8'h52
`define OP_LARGE_BLOCK_WIPE 8'hd8
`define OP_BYTE_PROGRAM 8'h02
`define OP_READ_ID 8'h9f
// engine states
`define ST_IDLE 2'd0
`define ST_SHIFT 2'd1
`define ST_WAIT 2'd2
// bits per byte on the wire
`define BITS_PER_BYTE 4'd8
`endif

// ### tb/flash_seq_props.sv
// port checker for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_seq_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FETCH_READY,
  input wire logic SPI_CS_N,
  input wire logic SPI_CLK,
  input wire logic SPI_DO
);
  logic [2:0] rise_r;
  logic sck_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // serial clock rises in a frame, modulo one byte
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rise_r <= 3'h0;
      sck_r <= 1'b0;
    end else begin
      sck_r <= SPI_CLK;
      rise_r <= SPI_CS_N ? 3'h0 : rise_r + {2'h0, SPI_CLK & ~sck_r};
    end
  end
  apb_one_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("apb answer late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  err_reads_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("bad error answer");
  fetch_pulse_a: assert property (FETCH_READY |=> !FETCH_READY)
    else $error("fetch ready held");
  idle_no_clock_a: assert property (SPI_CS_N |-> !SPI_CLK)
    else $error("clock while idle");
  whole_bytes_a: assert property ($rose(SPI_CS_N) |-> rise_r == 3'h0)
    else $error("partial byte");
  select_held_a: assert property ($fell(SPI_CS_N) |=> !SPI_CS_N [*8])
    else $error("select dropped");
  data_on_low_a: assert property (!SPI_CS_N && $changed(SPI_DO) |-> !SPI_CLK)
    else $error("data moved high");
endmodule // flash_seq_props
bind flash_seq flash_seq_props i_props (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FETCH_READY(FETCH_READY), .SPI_CS_N(SPI_CS_N), .SPI_CLK(SPI_CLK), .SPI_DO(SPI_DO));
`default_nettype wire

// ### tb/flash_model.sv
// behavioural serial flash: records sent bytes, answers a fixed pattern, or address-derived data for fast reads
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] rx [0:15];
  logic [7:0] sh;
  logic [7:0] tx;
  int nbits;
  // reply byte k; fast reads return address-derived data
  function automatic logic [7:0] reply(input int k);
    logic [23:0] a;
    a = {rx[1], rx[2], rx[3]} + 24'(k - 5);
    if (rx[0] == 8'h0b && k >= 5) return a[7:0] ^ 8'h5a;
    return 8'hc3 ^ 8'(k);
  endfunction
  initial miso = 1'b0;
  // new frame
  always @(negedge cs_n) begin
    nbits = 0;
    tx = 8'h00;
    miso = 1'b0;
  end
  // sample on rising serial clock
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    nbits++;
    if (nbits % 8 == 0 && nbits <= 128) rx[nbits / 8 - 1] = sh;
  end
  // shift out on falling serial clock
  always @(negedge sck) if (!cs_n) begin
    tx = (nbits % 8 == 0) ? reply(nbits / 8) : {tx[6:0], 1'b0};
    miso = tx[7];
  end
  // released line shows the inverse of the last bit
  always @(posedge cs_n) miso = ~miso;
endmodule // flash_model
`default_nettype wire

// ### tb/tb_flash_seq.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_seq;
  logic CLK, RST, PSEL, PENABLE, PWRITE, FETCH_REQ, LINK_CLK, er;
  logic PREADY, PSLVERR, FETCH_READY, SERIAL_DATA_IN, SPI_CS_N, SPI_CLK, SPI_DO;
  logic [7:0] PADDR, FETCH_DATA;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [23:0] FETCH_ADDR, base;
  logic [63:0] cmd;
  logic [7:0] ops [7] = '{8'h20, 8'h52, 8'hd8, 8'h02, 8'h00, 8'h9f, 8'h9f};
  logic [7:0] lens [7] = '{8'd4, 8'd4, 8'd4, 8'd5, 8'd1, 8'd4, 8'd10};
  int fails, cmp_count;
  flash_seq i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FETCH_REQ(FETCH_REQ),
    .FETCH_ADDR(FETCH_ADDR), .FETCH_READY(FETCH_READY), .FETCH_DATA(FETCH_DATA),
    .LINK_CLK(LINK_CLK), .SERIAL_DATA_IN(SERIAL_DATA_IN), .SPI_CS_N(SPI_CS_N),
    .SPI_CLK(SPI_CLK), .SPI_DO(SPI_DO));
  flash_model i_flash (.cs_n(SPI_CS_N), .sck(SPI_CLK), .mosi(SPI_DO),
    .miso(SERIAL_DATA_IN));
  // clocks: system and free-running link reference
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    LINK_CLK = 1'b0;
    #3;
    forever #80 LINK_CLK = ~LINK_CLK;
  end
  function automatic logic [7:0] rep(input int k);
    return 8'hc3 ^ 8'(k);
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude;
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic hang;
    fails++;
    conclude();
  endtask
  // one apb transfer, waits for the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (PREADY !== 1'b1) hang();
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // register-driven transfer and its checks
  task automatic xfer(input logic [63:0] c, input logic [7:0] len);
    int n;
    apb(1'b1, 8'h08, c[31:0]);
    apb(1'b1, 8'h0c, c[63:32]);
    apb(1'b1, 8'h04, {24'h0, len});
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[0], 1'b1);
    n = 0;
    while (rd[0] !== 1'b0 && n < 1000) begin
      apb(1'b0, 8'h00, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b0) hang();
    #1;
    chk(SPI_CS_N, 1'b1);
    chk(i_flash.nbits, len * 8);
    for (int i = 0; i < len; i++) chk(i_flash.rx[i], i < 8 ? c[i*8 +: 8] : 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    if (c[7:0] == 8'h9f && len == 4) chk(rd[23:0], {rep(3), rep(2), rep(1)});
    if (len == 10) chk(rd, {rep(4), rep(3), rep(2), rep(1)});
    apb(1'b0, 8'h14, 32'h0);
    if (len == 10) chk(rd, {rep(8), rep(7), rep(6), rep(5)});
  endtask
  // code fetch; a hit answers at the next edge
  task automatic fetch(input logic [23:0] a, input logic hit);
    int n;
    n = 1;
    @(posedge CLK);
    FETCH_REQ <= 1'b1;
    FETCH_ADDR <= a;
    @(posedge CLK);
    FETCH_REQ <= 1'b0;
    @(posedge CLK);
    while (FETCH_READY !== 1'b1 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (FETCH_READY !== 1'b1) hang();
    chk(FETCH_DATA, a[7:0] ^ 8'h5a);
    chk(n == 1, hit);
  endtask
  // main sequence
  initial begin
    {RST, PSEL, PENABLE, PWRITE, FETCH_REQ} = 5'h10;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    FETCH_ADDR = 24'h0;
    fails = 0;
    cmp_count = 0;
    void'($urandom(7281));
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 33'h100000000);
    foreach (ops[i]) begin
      cmd = {$urandom, $urandom};
      if (ops[i] != 8'h00) cmd[7:0] = ops[i];
      xfer(cmd, lens[i]);
    end
    base = {16'($urandom), 8'h00};
    for (int i = 0; i < 40; i++) fetch(base + 24'(i), 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[1:0], 2'b10);
    fetch(base + 24'd8, 1'b1);
    repeat (4) @(posedge CLK);
    #1;
    chk(SPI_CS_N, 1'b1);
    fetch(base + 24'd7, 1'b0);
    fetch(base + 24'd8, 1'b0);
    conclude();
  end
endmodule // tb_flash_seq
`default_nettype wire
